/* File: bench/line_activity_props.sv */
// assertions on the pins of the line activity block
// bound to line_activity_state_bits; one REF_CLK domain
`timescale 1ns/10ps
`default_nettype none
module line_activity_props (
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic PREADY,
	input wire logic SYNC_FOUND,
	input wire logic PRI_COUNT_ZERO,
	input wire logic ALT_COUNT_ZERO,
	input wire logic MEM_NONEXIST,
	input wire logic MEM_PARITY_ERR,
	input wire logic TX_GO,
	input wire logic RX_ENABLE,
	input wire logic RX_ACTIVE,
	input wire logic RX_HUNT,
	input wire logic QUEUE_FLUSH
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	wire xfer = PSEL && PENABLE && PREADY && PWRITE;
	property p_sync_up;
		RX_HUNT && RX_ENABLE && SYNC_FOUND |=> RX_ACTIVE;
	endproperty
	a_sync_up: assert property (p_sync_up) else $error("no sync");
	property p_sync_cause;
		$rose(RX_ACTIVE) |-> $past(SYNC_FOUND) && $past(RX_ENABLE);
	endproperty
	a_sync_cause: assert property (p_sync_cause) else $error("bad sync");
	property p_cnt_stop;
		PRI_COUNT_ZERO && ALT_COUNT_ZERO |=> !TX_GO;
	endproperty
	a_cnt_stop: assert property (p_cnt_stop) else $error("cnt go");
	property p_nxm_stop;
		$rose(MEM_NONEXIST) |=> !TX_GO;
	endproperty
	a_nxm_stop: assert property (p_nxm_stop) else $error("nxm go");
	property p_mpe_stop;
		$rose(MEM_PARITY_ERR) |=> !TX_GO;
	endproperty
	a_mpe_stop: assert property (p_mpe_stop) else $error("mpe go");
	property p_go_cause;
		$rose(TX_GO) |-> $past(xfer);
	endproperty
	a_go_cause: assert property (p_go_cause) else $error("stray go");
	property p_flush_cause;
		$rose(QUEUE_FLUSH) |-> $past(xfer);
	endproperty
	a_flush_cause: assert property (p_flush_cause) else $error("flush");
	property p_flush_once;
		QUEUE_FLUSH |=> !QUEUE_FLUSH;
	endproperty
	a_flush_once: assert property (p_flush_once) else $error("flush 2");
endmodule // line_activity_props
bind line_activity_state_bits line_activity_props chk_u (
	.REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PREADY(PREADY), .SYNC_FOUND(SYNC_FOUND),
	.PRI_COUNT_ZERO(PRI_COUNT_ZERO), .ALT_COUNT_ZERO(ALT_COUNT_ZERO),
	.MEM_NONEXIST(MEM_NONEXIST), .MEM_PARITY_ERR(MEM_PARITY_ERR),
	.TX_GO(TX_GO), .RX_ENABLE(RX_ENABLE), .RX_ACTIVE(RX_ACTIVE),
	.RX_HUNT(RX_HUNT), .QUEUE_FLUSH(QUEUE_FLUSH));
`default_nettype wire

/* File: bench/line_activity_state_bits_test.sv */
// register and line-event tests of the line activity block
// drives APB and the line event pins, counts from line_count_model
`timescale 1ns/10ps
`default_nettype none
module line_activity_state_bits_test;
	logic REF_CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, ld = 0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd;
	logic [4:0] ev = 5'h00;
	logic [7:0] n = 8'h00;
	logic PREADY, PSLVERR, TX_GO, RX_ENABLE, RX_ACTIVE, RX_HUNT, QF, IRQ, pz, az;
	int n_mismatch = 0, total_checks = 0, cyc = 0;
	line_count_model cnt_u (.clk(REF_CLK), .arst_n(ARST_N), .tx_go(TX_GO),
		.load(ld), .n(n), .pri_zero(pz), .alt_zero(az));
	line_activity_state_bits dut_u (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.SYNC_FOUND(ev[0]), .TX_CHAR_LOADED(ev[1]), .TX_DATA_NOT_AVAIL(ev[2]),
		.PRI_COUNT_ZERO(pz), .ALT_COUNT_ZERO(az), .MEM_NONEXIST(ev[3]),
		.MEM_PARITY_ERR(ev[4]), .TX_GO(TX_GO), .RX_ENABLE(RX_ENABLE),
		.RX_ACTIVE(RX_ACTIVE), .RX_HUNT(RX_HUNT), .QUEUE_FLUSH(QF), .IRQ(IRQ));
	always #2 REF_CLK = ~REF_CLK;
	task summarize;
		if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			summarize;
		end
	end
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	// full APB transfer; read data kept in rd, with PSLVERR in rd[31]
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1;
		do @(posedge REF_CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		rd[31] = PSLVERR;
		PSEL <= 0; PENABLE <= 0;
	endtask
	task fire(input logic [4:0] m);
		@(posedge REF_CLK) ev <= m;
		@(posedge REF_CLK) ev <= 5'h00;
		repeat (3) @(posedge REF_CLK);
		#1;
	endtask
	task txgo(input logic [7:0] k);
		@(posedge REF_CLK) begin ld <= 1; n <= k; end
		@(posedge REF_CLK) ld <= 0;
		apb(1, 12'h000, 32'h4);
		repeat (2) @(posedge REF_CLK);
		#1 chk("tx_go", 1, TX_GO);
	endtask
	initial begin
		repeat (4) @(posedge REF_CLK);
		ARST_N <= 1;
		apb(0, 12'h000, 0); chk("state", 0, rd);
		apb(0, 12'h008, 0); chk("mask", 0, rd);
		apb(0, 12'h010, 0); chk("unmapped", 32'h80000000, rd);
		apb(1, 12'h00C, 1);
		@(posedge REF_CLK);
		#1 chk("hunt", 1, RX_HUNT);
		fire(5'h01); chk("active", 1, RX_ACTIVE);
		apb(0, 12'h000, 0); chk("rd active", 1, rd[0]);
		apb(1, 12'h000, 2);
		#1 chk("flush", 1, QF);
		repeat (2) @(posedge REF_CLK);
		#1 chk("resync", 2'b10, {RX_HUNT, RX_ACTIVE});
		fire(5'h01); chk("reacq", 1, RX_ACTIVE);
		apb(1, 12'h00C, 0); apb(1, 12'h000, 2);
		fire(5'h01); chk("off", 0, RX_ACTIVE);
		txgo(8'd10);
		repeat (30) @(posedge REF_CLK);
		#1 chk("counts", 0, TX_GO);
		txgo(8'd90); apb(1, 12'h000, 0);
		repeat (2) @(posedge REF_CLK);
		#1 chk("abort", 0, TX_GO);
		txgo(8'd90); fire(5'h08); chk("nxm", 0, TX_GO);
		apb(0, 12'h000, 0); chk("nxm flag", 1, rd[4]);
		txgo(8'd90); fire(5'h10); chk("mpe", 0, TX_GO);
		apb(0, 12'h000, 0); chk("mpe flag", 1, rd[5]);
		apb(1, 12'h000, 0); apb(1, 12'h008, 4); apb(0, 12'h004, 0);
		fire(5'h06); chk("irq", 1, IRQ);
		apb(1, 12'h000, 8); apb(0, 12'h000, 0);
		chk("underrun", 32'h8, rd);
		apb(0, 12'h004, 0); chk("status", 1, rd[2]);
		repeat (2) @(posedge REF_CLK);
		#1 chk("irq clr", 0, IRQ);
		apb(1, 12'h000, 0); apb(0, 12'h000, 0); chk("cleared", 0, rd);
		summarize;
	end
endmodule // line_activity_state_bits_test
`default_nettype wire

/* File: bench/line_count_model.sv */
// principal and alternate transmit byte counts of the line
// counts down one byte a cycle while transmit-go is high
`timescale 1ns/10ps
`default_nettype none
module line_count_model (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       tx_go,
	input  wire logic       load,
	input  wire logic [7:0] n,
	output logic            pri_zero,
	output logic            alt_zero
);
	logic [7:0] pri_q;
	logic [7:0] alt_q;
	assign pri_zero = pri_q == 8'h00;
	assign alt_zero = alt_q == 8'h00;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pri_q <= 8'h00;
			alt_q <= 8'h00;
		end else if (load) begin
			pri_q <= n;
			alt_q <= n;
		end else if (tx_go && !pri_zero) begin
			pri_q <= pri_q - 8'h01;
		end else if (tx_go && !alt_zero) begin
			alt_q <= alt_q - 8'h01;
		end
	end
endmodule // line_count_model
`default_nettype wire

/* File: verilog/line_activity_consts.vh */
// register offsets, field positions and reset values for the line
// activity block; definitions only, included by line_activity_state_bits
`ifndef LINE_ACTIVITY_CONSTS_VH
`define LINE_ACTIVITY_CONSTS_VH

// byte offsets on the register bus
`define OFF_LINE_STATE   12'h000
`define OFF_IRQ_STATUS   12'h004
`define OFF_IRQ_MASK     12'h008
`define OFF_LINE_CTRL    12'h00C

// per_line_activity_register fields
`define LS_RX_ACTIVE     0
`define LS_RESYNC        1
`define LS_TX_GO         2
`define LS_UNDERRUN      3
`define LS_NXM           4
`define LS_MPE           5
`define LS_WIDTH         16

// interrupt status and mask fields
`define EV_RX_ACTIVE     0
`define EV_TX_STOP       1
`define EV_UNDERRUN      2
`define EV_NXM           3
`define EV_MPE           4
`define EV_WIDTH         5

// line control fields
`define LC_RX_ENABLE     0

// reset values
`define RST_LINE_STATE   16'h0000
`define RST_IRQ_MASK     5'h00
`define RST_LINE_CTRL    1'h0

// register select codes
`define SEL_NONE         3'h0
`define SEL_LINE_STATE   3'h1
`define SEL_IRQ_STATUS   3'h2
`define SEL_IRQ_MASK     3'h3
`define SEL_LINE_CTRL    3'h4

`endif

/* File: verilog/line_activity_state_bits.v */
// per-line activity control and status bits, reached over APB3
// assumes line datapath events arrive as one-cycle pulses on REF_CLK
//
// Notes on behaviour
// - receiver-active sets once an enabled receiver finds the sync characters
// - writing one to resync restarts the sync search or stops reception
// - the sync search runs only while the line receiver is enabled
// - a successful resync search sets receiver-active to one
// - a resync request flushes this line's queued receive characters
// - host sets transmit-go; transmission runs while it stays set
// - transmit-go clears when principal and alternate counts are both zero
// - transmit-go clears when nonexistent-memory or parity flag becomes set
// - underrun sets when a loaded character meets data-not-available
// - underrun clears only by a written zero, whether or not the host has read it
// - a set underrun means at least one idle sync went out
// - nonexistent-memory flag sets when a transmit fetch gets no answer
// - parity flag sets on a memory parity error during transmit fetch
`include "line_activity_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module line_activity_state_bits #(
	parameter ADDR_WIDTH = 12
) (
	input  wire                  REF_CLK,
	input  wire                  ARST_N,
	input  wire                  PSEL,
	input  wire                  PENABLE,
	input  wire                  PWRITE,
	input  wire [ADDR_WIDTH-1:0] PADDR,
	input  wire [31:0]           PWDATA,
	output reg  [31:0]           PRDATA,
	output reg                   PREADY,
	output reg                   PSLVERR,
	input  wire                  SYNC_FOUND,
	input  wire                  TX_CHAR_LOADED,
	input  wire                  TX_DATA_NOT_AVAIL,
	input  wire                  PRI_COUNT_ZERO,
	input  wire                  ALT_COUNT_ZERO,
	input  wire                  MEM_NONEXIST,
	input  wire                  MEM_PARITY_ERR,
	output reg                   TX_GO,
	output reg                   RX_ENABLE,
	output wire                  RX_ACTIVE,
	output wire                  RX_HUNT,
	output reg                   QUEUE_FLUSH,
	output reg                   IRQ
);

	// register select from the word address; bits below the word ignored
	function [2:0] reg_select;
		input [ADDR_WIDTH-1:0] addr;
		reg   [11:0]           word;
		begin
			word = {addr[11:2], 2'b00};
			case (word)
			`OFF_LINE_STATE: reg_select = `SEL_LINE_STATE;
			`OFF_IRQ_STATUS: reg_select = `SEL_IRQ_STATUS;
			`OFF_IRQ_MASK:   reg_select = `SEL_IRQ_MASK;
			`OFF_LINE_CTRL:  reg_select = `SEL_LINE_CTRL;
			default:         reg_select = `SEL_NONE;
			endcase
			// address bits above the map must all be zero
			if (|(addr >> 12))
				reg_select = `SEL_NONE;
		end
	endfunction

	wire [2:0]            sel;
	wire                  access;
	wire                  commit;
	wire                  answer;
	wire                  wr_commit;
	wire                  rd_commit;
	wire                  wr_line;
	wire                  wr_mask;
	wire                  wr_ctrl;
	wire                  rd_status;

	reg                   underrun_q;
	reg                   nxm_q;
	reg                   mpe_q;
	reg  [`EV_WIDTH-1:0]  status_q;
	reg  [`EV_WIDTH-1:0]  status_d;
	reg  [`EV_WIDTH-1:0]  mask_q;
	reg  [`EV_WIDTH-1:0]  mask_d;
	reg                   tx_go_d;
	reg                   rx_enable_d;
	reg  [31:0]           rdata_d;
	reg  [`LS_WIDTH-1:0]  line_state;

	wire                  resync_req;
	wire                  underrun_set;
	wire                  nxm_rise;
	wire                  mpe_rise;
	wire                  counts_done;
	wire                  tx_stop;
	wire                  tx_done_ev;
	wire                  active_rise;
	wire                  underrun_d;
	wire                  nxm_d;
	wire                  mpe_d;
	reg  [`EV_WIDTH-1:0]  events;

	// bus side: one wait state, so a transfer takes setup plus two access
	assign sel       = reg_select(PADDR);
	assign access    = PSEL && PENABLE;
	assign commit    = access && PREADY;
	assign answer    = access && !PREADY;
	assign wr_commit = commit && PWRITE && (sel != `SEL_NONE);
	assign rd_commit = commit && !PWRITE;
	assign wr_line   = wr_commit && (sel == `SEL_LINE_STATE);
	assign wr_mask   = wr_commit && (sel == `SEL_IRQ_MASK);
	assign wr_ctrl   = wr_commit && (sel == `SEL_LINE_CTRL);
	assign rd_status = rd_commit && (sel == `SEL_IRQ_STATUS);

	// ready is a one-cycle pulse in the second access cycle
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PREADY <= 1'b0;
		end else begin
			PREADY <= answer;
		end
	end

	// data and error captured a cycle ahead of ready, then held, so
	// the status read-clear knows exactly what was returned
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end else if (answer) begin
			PSLVERR <= (sel == `SEL_NONE);
			PRDATA  <= PWRITE ? 32'h00000000 : rdata_d;
		end else if (!access) begin
			PSLVERR <= 1'b0;
		end
	end

	// read view of the activity register; unused bits read zero
	always @* begin
		line_state                = `RST_LINE_STATE;
		line_state[`LS_RX_ACTIVE] = RX_ACTIVE;
		line_state[`LS_RESYNC]    = RX_HUNT;
		line_state[`LS_TX_GO]     = TX_GO;
		line_state[`LS_UNDERRUN]  = underrun_q;
		line_state[`LS_NXM]       = nxm_q;
		line_state[`LS_MPE]       = mpe_q;
	end

	always @* begin
		case (sel)
		`SEL_LINE_STATE: begin
			rdata_d = {16'h0000, line_state};
		end
		`SEL_IRQ_STATUS: begin
			rdata_d = {27'h0000000, status_q};
		end
		`SEL_IRQ_MASK: begin
			rdata_d = {27'h0000000, mask_q};
		end
		`SEL_LINE_CTRL: begin
			rdata_d = {31'h00000000, RX_ENABLE};
		end
		default: begin
			rdata_d = 32'h00000000;
		end
		endcase
	end

	// receiver side
	assign resync_req = wr_line && PWDATA[`LS_RESYNC];

	always @* begin
		rx_enable_d = RX_ENABLE;
		if (wr_ctrl)
			rx_enable_d = PWDATA[`LC_RX_ENABLE];
	end

	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RX_ENABLE <= `RST_LINE_CTRL;
		end else begin
			RX_ENABLE <= rx_enable_d;
		end
	end

	// hunt is gated by the enable inside the state machine
	sync_hunt_fsm u_hunt (
		.clk           (REF_CLK),
		.arst_n        (ARST_N),
		.rx_enable     (RX_ENABLE),
		.resync        (resync_req),
		.sync_found    (SYNC_FOUND),
		.active_q      (RX_ACTIVE),
		.hunting_q     (RX_HUNT),
		.active_rise_q (active_rise)
	);

	// flush even when the receiver is disabled; stale characters must go
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			QUEUE_FLUSH <= 1'b0;
		end else begin
			QUEUE_FLUSH <= resync_req;
		end
	end

	// transmitter side
	assign underrun_set = TX_CHAR_LOADED && TX_DATA_NOT_AVAIL;
	assign nxm_rise     = MEM_NONEXIST && !nxm_q;
	assign mpe_rise     = MEM_PARITY_ERR && !mpe_q;
	assign counts_done  = PRI_COUNT_ZERO && ALT_COUNT_ZERO;
	assign tx_stop      = counts_done || nxm_rise || mpe_rise;
	assign tx_done_ev   = TX_GO && tx_stop;

	// hardware stop outranks a host write in the same cycle
	always @* begin
		tx_go_d = TX_GO;
		if (tx_stop)
			tx_go_d = 1'b0;
		else if (wr_line)
			tx_go_d = PWDATA[`LS_TX_GO];
	end

	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			TX_GO <= 1'b0;
		end else begin
			TX_GO <= tx_go_d;
		end
	end

	// hardware-set flag: a set wins over a written zero in the same
	// cycle, and a written one is ignored
	function flag_next;
		input cur;
		input set;
		input wr;
		input wbit;
		begin
			if (set)
				flag_next = 1'b1;
			else if (wr && !wbit)
				flag_next = 1'b0;
			else
				flag_next = cur;
		end
	endfunction

	assign underrun_d = flag_next(underrun_q, underrun_set, wr_line,
	                              PWDATA[`LS_UNDERRUN]);
	assign nxm_d      = flag_next(nxm_q, MEM_NONEXIST, wr_line,
	                              PWDATA[`LS_NXM]);
	assign mpe_d      = flag_next(mpe_q, MEM_PARITY_ERR, wr_line,
	                              PWDATA[`LS_MPE]);

	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			underrun_q <= 1'b0;
		end else begin
			underrun_q <= underrun_d;
		end
	end

	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			nxm_q <= 1'b0;
		end else begin
			nxm_q <= nxm_d;
		end
	end

	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mpe_q <= 1'b0;
		end else begin
			mpe_q <= mpe_d;
		end
	end

	// read-clear drops only the bits the read returned, so an event
	// landing between data capture and commit is not lost
	function [`EV_WIDTH-1:0] status_next;
		input [`EV_WIDTH-1:0] cur;
		input                 rd;
		input [`EV_WIDTH-1:0] seen;
		input [`EV_WIDTH-1:0] ev;
		begin
			status_next = cur;
			if (rd)
				status_next = status_next & ~seen;
			status_next = status_next | ev;
		end
	endfunction

	always @* begin
		events                = {`EV_WIDTH{1'b0}};
		events[`EV_RX_ACTIVE] = active_rise;
		events[`EV_TX_STOP]   = tx_done_ev;
		events[`EV_UNDERRUN]  = underrun_set;
		events[`EV_NXM]       = nxm_rise;
		events[`EV_MPE]       = mpe_rise;
	end

	always @* begin
		status_d = status_next(status_q, rd_status,
		                       PRDATA[`EV_WIDTH-1:0], events);
	end

	always @* begin
		mask_d = mask_q;
		if (wr_mask)
			mask_d = PWDATA[`EV_WIDTH-1:0];
	end

	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			status_q <= {`EV_WIDTH{1'b0}};
		end else begin
			status_q <= status_d;
		end
	end

	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mask_q <= `RST_IRQ_MASK;
		end else begin
			mask_q <= mask_d;
		end
	end

	// built from next values so the flop tracks the registers with
	// no extra cycle of lag
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(status_d & mask_d);
		end
	end

endmodule // line_activity_state_bits

`default_nettype wire

/* File: verilog/sync_hunt_fsm.v */
// receiver synchronisation state of one line: idle, hunting, active
// assumes sync_found and resync are one-cycle pulses on clk
`timescale 1ns/10ps
`default_nettype none

module sync_hunt_fsm (
	input  wire clk,
	input  wire arst_n,
	input  wire rx_enable,
	input  wire resync,
	input  wire sync_found,
	output reg  active_q,
	output reg  hunting_q,
	output reg  active_rise_q
);

	localparam [1:0] ST_IDLE   = 2'h0;
	localparam [1:0] ST_HUNT   = 2'h1;
	localparam [1:0] ST_ACTIVE = 2'h2;

	reg [1:0] state_q;
	reg [1:0] state_d;

	always @* begin
		state_d = state_q;
		case (state_q)
		ST_IDLE: begin
			if (rx_enable)
				state_d = ST_HUNT;
		end
		ST_HUNT: begin
			if (!rx_enable)
				state_d = ST_IDLE;
			else if (sync_found && !resync)
				state_d = ST_ACTIVE;
		end
		ST_ACTIVE: begin
			if (!rx_enable)
				state_d = ST_IDLE;
			else if (resync)
				state_d = ST_HUNT;
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q       <= ST_IDLE;
			active_q      <= 1'b0;
			hunting_q     <= 1'b0;
			active_rise_q <= 1'b0;
		end else begin
			state_q       <= state_d;
			active_q      <= (state_d == ST_ACTIVE);
			hunting_q     <= (state_d == ST_HUNT);
			active_rise_q <= (state_d == ST_ACTIVE) &&
			                 (state_q != ST_ACTIVE);
		end
	end

endmodule // sync_hunt_fsm

`default_nettype wire
